// ---- rtl/gpmi_port_top.sv ----
// Four eight-pin ports with APB register access
//
// Local design decisions: register access over APB and the placing of the registers.
`timescale 1ns/1ns
module gpmi_port_top (
  input  wire logic        ref_clk,
  input  wire logic        reset_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [31:0] pinIn,
  output logic      [31:0] pinOut,
  output logic      [31:0] pinOe,
  input  wire logic [15:0] altOut,
  input  wire logic [15:0] altOe,
  output logic      [31:0] irqReq
);

  //============================================================================
  // State
  typedef struct packed {
    logic [3:0][7:0] data;
    logic [3:0][7:0] dir;
    logic [3:0][7:0] modeLo;
    logic [3:0][7:0] modeHi;
    logic [31:0]     rdData;
    logic            slvErr;
  } gpmi_regs_t;

  gpmi_regs_t state;
  gpmi_regs_t next_state;
  logic [9:0]      idx;
  logic            aligned;
  logic            setup;
  logic            access;
  logic [3:0]      hitData;
  logic [3:0]      hitDir;
  logic [3:0]      hitModeLo;
  logic [3:0]      hitModeHi;
  logic [31:0]     readVal;
  logic            mapped;
  logic [3:0][7:0] clearBits;
  logic [31:0]     pinLevel;
  logic [31:0]     edgeArmed;

  assign idx = paddr[11:gpmi_pkg::ADDR_LSB];
  assign aligned = (paddr[1:0] == 2'b00);
  assign setup = psel & ~penable;
  assign access = psel & penable;
  assign pready = access;

  //============================================================================
  // Decode and next state
  always_comb
  begin
    next_state = state;
    readVal = gpmi_pkg::READ_ZERO;
    mapped = 1'b0;
    for (int p = 0; p < gpmi_pkg::PORTS; p++)
    begin
      hitData[p] = aligned && (idx == gpmi_pkg::IDX_DATA[p]);
      hitDir[p] = aligned && (idx == gpmi_pkg::IDX_DIR[p]);
      hitModeLo[p] = aligned && (idx == gpmi_pkg::IDX_MODE_LO[p]);
      hitModeHi[p] = aligned && (idx == gpmi_pkg::IDX_MODE_HI[p]);
      if (hitData[p])
      begin
        readVal[7:0] = pinLevel[p*8 +: 8]; // see R03
      end
      if (hitDir[p])
      begin
        readVal[7:0] = state.dir[p];
      end
      if (hitModeLo[p])
      begin
        readVal[7:0] = state.modeLo[p];
      end
      if (hitModeHi[p])
      begin
        readVal[7:0] = state.modeHi[p];
      end
      mapped = mapped | hitData[p] | hitDir[p] | hitModeLo[p] | hitModeHi[p];
      // Ones written to an armed edge pin only clear; the stored bit stays
      clearBits[p] = (access && pwrite && hitData[p]) ? (pwdata[7:0] & edgeArmed[p*8 +: 8]) : 8'h00; // see R11 see R18
      if (access && pwrite)
      begin
        if (hitData[p])
        begin
          for (int b = 0; b < gpmi_pkg::PINS_PER_PORT; b++)
          begin
            if (!edgeArmed[p*8+b])
            begin
              next_state.data[p][b] = pwdata[b]; // see R12
            end
          end
        end
        if (hitDir[p])
        begin
          next_state.dir[p] = pwdata[7:0]; // see R02
        end
        if (hitModeLo[p])
        begin
          next_state.modeLo[p] = pwdata[7:0];
        end
        if (hitModeHi[p])
        begin
          next_state.modeHi[p] = pwdata[7:0];
        end
      end
    end
    // Answer captured in setup so read data leaves a flip-flop
    if (setup)
    begin
      next_state.rdData = pwrite ? gpmi_pkg::READ_ZERO : readVal;
      next_state.slvErr = ~mapped;
    end
  end

  //============================================================================
  // Registers
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state.data <= {gpmi_pkg::PORTS{gpmi_pkg::RST_DATA}};
      state.dir <= {gpmi_pkg::PORTS{gpmi_pkg::RST_DIR}}; // see R04
      state.modeLo <= {gpmi_pkg::PORTS{gpmi_pkg::RST_MODE_LO}};
      state.modeHi <= {gpmi_pkg::PORTS{gpmi_pkg::RST_MODE_HI}};
      state.rdData <= gpmi_pkg::READ_ZERO;
      state.slvErr <= 1'b0;
    end
    else
    begin
      state <= next_state;
    end
  end

  assign prdata = state.rdData;
  assign pslverr = state.slvErr & access;

  //============================================================================
  // Pins
  for (genvar gp = 0; gp < gpmi_pkg::PINS; gp++)
  begin : g_pin
    localparam int PORT = gp / gpmi_pkg::PINS_PER_PORT;
    localparam int BIT = gp % gpmi_pkg::PINS_PER_PORT;
    localparam bit HAS_ALT = (PORT >= gpmi_pkg::ALT_PORT_FIRST);
    gpmi_pin #(
      .HAS_ALT (HAS_ALT)
    ) u_pin ( // see R01
      .ref_clk   (ref_clk),
      .reset_n   (reset_n),
      .pinIn     (pinIn[gp]),
      .modeHi    (state.modeHi[PORT][BIT]),
      .modeLo    (state.modeLo[PORT][BIT]),
      .dir       (state.dir[PORT][BIT]),
      .dataBit   (state.data[PORT][BIT]),
      .clearReq  (clearBits[PORT][BIT]),
      .altOut    (altOut[gp % gpmi_pkg::ALT_PINS]),
      .altOe     (altOe[gp % gpmi_pkg::ALT_PINS]),
      .pinOut    (pinOut[gp]),
      .pinOe     (pinOe[gp]),
      .irqReq    (irqReq[gp]),
      .pinLevel  (pinLevel[gp]),
      .edgeArmed (edgeArmed[gp])
    );
  end

endmodule : gpmi_port_top

// ---- rtl/gpmi_pkg.sv ----
// Constants, register indices and mode codes of the four-port pin block
//==============================================================================
// Behaviour
// R01 - Thirty-two pins as four eight-pin ports
// R02 - Four control bits select each pin's mode
// R03 - Data register reads return sampled pin levels
// R04 - Reset leaves every pin a plain input
// R05 - Mode 1 drives data bit push-pull
// R06 - Mode 2 input, output tristated, data ignored
// R07 - Mode 3 open-drain: zero drives low
// R08 - Mode 4 open-source: one drives high
// R09 - Reserved mode 5 stays tristated
// R10 - Mode 6 interrupts on both edges
// R11 - Dual-edge: writing one clears the request
// R12 - Software sets data bit before edge modes
// R13 - Mode 7 on C, D hands pin to alternate
// R14 - Mode 7 on A, B acts as mode 2
// R15 - Mode 8 requests while level equals data bit
// R16 - Level held two samples; request follows level
// R17 - Mode 9 single edge chosen by data bit
// R18 - Single-edge request held until one written
// R19 - Each pin has its own request output
// R20 - Edges found from successive pin samples
//==============================================================================
package gpmi_pkg;

  //============================================================================
  // Geometry
  localparam int PORTS          = 4;
  localparam int PINS_PER_PORT  = 8;
  localparam int PINS           = 32;
  localparam int ALT_PORT_FIRST = 2;
  localparam int ALT_PINS       = 16;

  //============================================================================
  // Register indices; byte address is four times the index
  localparam int ADDR_W   = 12;
  localparam int ADDR_LSB = 2;
  localparam logic [9:0] IDX_DATA_A    = 10'h096;
  localparam logic [9:0] IDX_DIR_A     = 10'h097;
  localparam logic [9:0] IDX_MODE_LO_A = 10'h098;
  localparam logic [9:0] IDX_MODE_HI_A = 10'h099;
  localparam logic [9:0] IDX_DATA_B    = 10'h09A;
  localparam logic [9:0] IDX_DIR_B     = 10'h09B;
  localparam logic [9:0] IDX_MODE_LO_B = 10'h09C;
  localparam logic [9:0] IDX_MODE_HI_B = 10'h09D;
  localparam logic [9:0] IDX_DATA_C    = 10'h09E;
  localparam logic [9:0] IDX_DIR_C     = 10'h09F;
  localparam logic [9:0] IDX_MODE_LO_C = 10'h0A0;
  localparam logic [9:0] IDX_MODE_HI_C = 10'h0A1;
  localparam logic [9:0] IDX_DATA_D    = 10'h0A2;
  localparam logic [9:0] IDX_DIR_D     = 10'h0A3;
  localparam logic [9:0] IDX_MODE_LO_D = 10'h0A4;
  localparam logic [9:0] IDX_MODE_HI_D = 10'h0A5;
  localparam logic [3:0][9:0] IDX_DATA    = {IDX_DATA_D, IDX_DATA_C, IDX_DATA_B, IDX_DATA_A};
  localparam logic [3:0][9:0] IDX_DIR     = {IDX_DIR_D, IDX_DIR_C, IDX_DIR_B, IDX_DIR_A};
  localparam logic [3:0][9:0] IDX_MODE_LO = {IDX_MODE_LO_D, IDX_MODE_LO_C, IDX_MODE_LO_B, IDX_MODE_LO_A};
  localparam logic [3:0][9:0] IDX_MODE_HI = {IDX_MODE_HI_D, IDX_MODE_HI_C, IDX_MODE_HI_B, IDX_MODE_HI_A};

  //============================================================================
  // Reset values
  localparam logic [7:0]  RST_DATA    = 8'h00;
  localparam logic [7:0]  RST_DIR     = 8'hFF;
  localparam logic [7:0]  RST_MODE_LO = 8'h00;
  localparam logic [7:0]  RST_MODE_HI = 8'h00;
  localparam logic [31:0] READ_ZERO   = 32'h0000_0000;

  //============================================================================
  // Pin configuration: {mode_select_high, mode_select_low, pin_direction}
  typedef enum logic [2:0] {
    CFG_PUSH_PULL  = 3'b000,
    CFG_INPUT      = 3'b001,
    CFG_OPEN_DRAIN = 3'b010,
    CFG_OPEN_SRC   = 3'b011,
    CFG_DUAL_EDGE  = 3'b100,
    CFG_ALTERNATE  = 3'b101,
    CFG_LEVEL      = 3'b110,
    CFG_ONE_EDGE   = 3'b111
  } gpmi_cfg_t;

endpackage : gpmi_pkg

// ---- rtl/gpmi_pin.sv ----
// One port pin: sampling, drive control and interrupt request
`timescale 1ns/1ns
module gpmi_pin #(
  parameter bit HAS_ALT = 1'b0
) (
  input  wire logic ref_clk,
  input  wire logic reset_n,
  input  wire logic pinIn,
  input  wire logic modeHi,
  input  wire logic modeLo,
  input  wire logic dir,
  input  wire logic dataBit,
  input  wire logic clearReq,
  input  wire logic altOut,
  input  wire logic altOe,
  output logic      pinOut,
  output logic      pinOe,
  output logic      irqReq,
  output logic      pinLevel,
  output logic      edgeArmed
);

  //============================================================================
  // State
  typedef struct packed {
    logic sample;
    logic prev;
    logic pending;
    logic irq;
    logic drvOut;
    logic drvOe;
  } gpmi_pin_state_t;

  gpmi_pin_state_t state;
  gpmi_pin_state_t next_state;
  gpmi_pkg::gpmi_cfg_t cfg;
  logic rise;
  logic fall;
  logic hit;
  logic isEdge;
  logic levelHit;
  logic drv;
  logic oe;

  //============================================================================
  // Next state
  always_comb
  begin
    next_state = state;
    cfg = gpmi_pkg::gpmi_cfg_t'({modeHi, modeLo, dir}); // see R02
    next_state.sample = pinIn; // see R03
    next_state.prev = state.sample;
    rise = state.sample & ~state.prev; // see R20
    fall = ~state.sample & state.prev; // see R20
    hit = 1'b0;
    isEdge = 1'b0;
    levelHit = 1'b0;
    drv = 1'b0;
    oe = 1'b0;
    unique case (cfg)
      gpmi_pkg::CFG_PUSH_PULL:
      begin
        oe = 1'b1; // see R05
        drv = dataBit;
      end
      gpmi_pkg::CFG_INPUT:
      begin
        oe = 1'b0; // see R06
      end
      gpmi_pkg::CFG_OPEN_DRAIN:
      begin
        oe = ~dataBit; // see R07
        drv = 1'b0;
      end
      gpmi_pkg::CFG_OPEN_SRC:
      begin
        oe = dataBit; // see R08
        drv = 1'b1;
      end
      gpmi_pkg::CFG_DUAL_EDGE:
      begin
        // Data bit 0 is the reserved mode, tristated and silent
        if (dataBit) // see R09
        begin
          isEdge = 1'b1;
          hit = rise | fall; // see R10
        end
      end
      gpmi_pkg::CFG_ALTERNATE:
      begin
        if (HAS_ALT) // see R14
        begin
          drv = altOut; // see R13
          oe = altOe;
        end
      end
      gpmi_pkg::CFG_LEVEL:
      begin
        // Two matching samples in a row, dropped once the level goes
        levelHit = (state.sample == dataBit) && (state.prev == dataBit); // see R15 see R16
      end
      gpmi_pkg::CFG_ONE_EDGE:
      begin
        isEdge = 1'b1;
        hit = dataBit ? rise : fall; // see R17
      end
    endcase
    // New edge beats a clear in the same cycle
    next_state.pending = isEdge & (hit | (state.pending & ~clearReq)); // see R11 see R18
    next_state.irq = isEdge ? next_state.pending : levelHit; // see R19
    next_state.drvOut = drv;
    next_state.drvOe = oe;
  end

  //============================================================================
  // Registers
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state <= '0; // see R04
    end
    else
    begin
      state <= next_state;
    end
  end

  assign pinOut = state.drvOut;
  assign pinOe = state.drvOe;
  assign irqReq = state.irq;
  assign pinLevel = state.sample;
  assign edgeArmed = isEdge;

endmodule : gpmi_pin

// ---- verif/gpmi_port_top_assertions.sv ----
// Checker for the four-port pin block
`timescale 1ns/1ns
module gpmi_port_top_checker (
  input wire logic        ref_clk,
  input wire logic        reset_n,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [31:0] pinIn,
  input wire logic [31:0] pinOut,
  input wire logic [31:0] pinOe,
  input wire logic [15:0] altOut,
  input wire logic [15:0] altOe,
  input wire logic [31:0] irqReq
);
  // ======
  // Bus answer
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  wire logic acc = psel && penable;
  wire logic wacc = psel && penable && pwrite;
  a_ready_zero: assert property (acc |-> pready) else $error("pready missing");
  a_misalign_err: assert property (acc && paddr[1:0] != 2'b00 |-> pslverr) else $error("no error");
  a_err_read_zero: assert property (acc && pslverr && !pwrite |-> prdata == 32'h0000_0000) else $error("bad data");
  a_read_upper: assert property (acc && !pwrite |-> prdata[31:8] == 24'h00_0000) else $error("upper bits set");
  a_read_sample: assert property (acc && !pwrite && paddr == 12'h258 |-> prdata[7:0] == $past(pinIn[7:0], 2))
    else $error("read not pin level");
  // ======
  // Pins; only writes or the alternate side may move the drive
  a_reset_idle: assert property ($rose(reset_n) |-> pinOe == 32'h0000_0000 && irqReq == 32'h0000_0000)
    else $error("pins not idle");
  a_oe_cause: assert property ($changed(pinOe) |-> $past(wacc) || $past(wacc, 2) || $past(altOe) != $past(altOe, 2)
    || $past(altOe, 2) != $past(altOe, 3)) else $error("enable moved alone");
  a_out_cause: assert property ($changed(pinOut) |-> $past(wacc) || $past(wacc, 2) || $past(altOut) != $past(altOut, 2)
    || $past(altOut, 2) != $past(altOut, 3)) else $error("drive moved alone");
  c_irq: cover property (irqReq != 32'h0000_0000);
  c_err: cover property (acc && pslverr);
  c_alt: cover property (altOe != 16'h0000 && pinOe[31:16] != 16'h0000);
endmodule : gpmi_port_top_checker

bind gpmi_port_top gpmi_port_top_checker u_chk (.ref_clk(ref_clk), .reset_n(reset_n), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe), .altOut(altOut), .altOe(altOe),
  .irqReq(irqReq));

// ---- verif/gpmi_ext_model.sv ----
// External devices on the port pins
`timescale 1ns/1ns
module gpmi_ext_model (
  input  wire logic [31:0] pinOut,
  input  wire logic [31:0] pinOe,
  input  wire logic [31:0] ext,
  output logic      [31:0] pinIn
);
  // ======
  // Block drive wins; otherwise the outside level shows
  assign pinIn = (pinOe & pinOut) | (~pinOe & ext);
endmodule : gpmi_ext_model

// ---- verif/tb_gpio_port_mode_interrupt.sv ----
// Testbench for the four-port pin block
`timescale 1ns/1ns
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin error_cnt++; $display("[ERR] %0t got %h want %h", $time, a, b); end end
module tb_gpio_port_mode_interrupt;
  // ======
  // Signals
  logic        ref_clk = 1'b0;
  logic        reset_n = 1'b0;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [11:0] paddr   = 12'h000;
  logic [31:0] pwdata  = 32'h0000_0000;
  logic [31:0] ext     = 32'h5A3C_96F0;
  logic [15:0] altOut  = 16'h0FF0;
  logic [15:0] altOe   = 16'h3CC3;
  logic [31:0] prdata, pinIn, pinOut, pinOe, irqReq;
  logic        pready, pslverr;
  logic        lastErr = 1'b0;
  logic [7:0]  rv;
  int          error_cnt = 0;
  int          checks_done = 0;
  always #4 ref_clk = ~ref_clk;
  gpmi_port_top dut (.ref_clk(ref_clk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .pinIn(pinIn),
    .pinOut(pinOut), .pinOe(pinOe), .altOut(altOut), .altOe(altOe), .irqReq(irqReq));
  gpmi_ext_model ext_dev (.pinOut(pinOut), .pinOe(pinOe), .ext(ext), .pinIn(pinIn));
  // ======
  // Tasks
  task stop_test;
    if (error_cnt == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : stop_test
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d, output logic [7:0] r);
    int n;
    n = 0;
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= {24'h00_0000, d};
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    while (pready !== 1'b1)
    begin
      n++;
      if (n > 20)
      begin
        error_cnt++;
        $display("[ERR] %0t bus hang", $time);
        stop_test();
      end
      @(posedge ref_clk);
    end
    r = prdata[7:0];
    lastErr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask : apb
  task automatic wr(input logic [9:0] idx, input logic [7:0] d);
    logic [7:0] r;
    apb(1'b1, {idx, 2'b00}, d, r);
  endtask : wr
  task automatic rdc(input logic [9:0] idx, input logic [7:0] exp);
    logic [7:0] r;
    apb(1'b0, {idx, 2'b00}, 8'h00, r);
    `CHK(r, exp)
  endtask : rdc
  // Data first, so edge modes are entered already armed
  task automatic cfg(input int p, input logic [7:0] hi, lo, dir, dat);
    wr(gpmi_pkg::IDX_DATA[p], dat);
    wr(gpmi_pkg::IDX_DIR[p], dir);
    wr(gpmi_pkg::IDX_MODE_LO[p], lo);
    wr(gpmi_pkg::IDX_MODE_HI[p], hi);
  endtask : cfg
  task automatic pins(input int p, input logic [7:0] oe, out);
    repeat (2) @(posedge ref_clk);
    `CHK(pinOe[8*p+:8], oe)
    `CHK(pinOut[8*p+:8] & oe, out)
  endtask : pins
  task automatic irqw(input int i, input logic v);
    int n;
    n = 0;
    while (irqReq[i] !== v && n < 10)
    begin
      @(posedge ref_clk);
      n++;
    end
    `CHK(irqReq[i], v)
    // A request that never came ends the run at once
    if (irqReq[i] !== v)
      stop_test();
  endtask : irqw
  // ======
  // Sequence
  initial
  begin
    repeat (16) @(posedge ref_clk);
    reset_n <= 1'b1;
    @(posedge ref_clk);
    for (int p = 0; p < 4; p++)
    begin
      rdc(gpmi_pkg::IDX_DIR[p], 8'hFF);
      rdc(gpmi_pkg::IDX_MODE_LO[p], 8'h00);
      rdc(gpmi_pkg::IDX_MODE_HI[p], 8'h00);
      rdc(gpmi_pkg::IDX_DATA[p], ext[8*p+:8]);
      pins(p, 8'h00, 8'h00);
    end
    rdc(10'h000, 8'h00);
    `CHK(lastErr, 1'b1)
    // Misaligned write must be refused and leave the pin an input
    apb(1'b1, {gpmi_pkg::IDX_DIR[0], 2'b01}, 8'h00, rv);
    `CHK(lastErr, 1'b1)
    rdc(gpmi_pkg::IDX_DIR[0], 8'hFF);
    `CHK(lastErr, 1'b0)
    pins(0, 8'h00, 8'h00);
    cfg(0, 8'h00, 8'h00, 8'h00, 8'hA5);
    pins(0, 8'hFF, 8'hA5);
    rdc(gpmi_pkg::IDX_DATA[0], 8'hA5);
    cfg(0, 8'h00, 8'h00, 8'hFF, 8'hA5);
    pins(0, 8'h00, 8'h00);
    cfg(1, 8'h00, 8'hFF, 8'h00, 8'h0F);
    pins(1, 8'hF0, 8'h00);
    cfg(1, 8'h00, 8'hFF, 8'hFF, 8'h0F);
    pins(1, 8'h0F, 8'h0F);
    cfg(1, 8'hFF, 8'h00, 8'h00, 8'h00);
    pins(1, 8'h00, 8'h00);
    cfg(2, 8'hFF, 8'h00, 8'hFF, 8'h00);
    pins(2, 8'hC3, 8'hC0);
    cfg(3, 8'hFF, 8'h00, 8'hFF, 8'h00);
    pins(3, 8'h3C, 8'h0C);
    cfg(0, 8'hFF, 8'h00, 8'hFF, 8'h00);
    pins(0, 8'h00, 8'h00);
    ext[31:24] <= 8'hFF;
    cfg(3, 8'hFF, 8'hFF, 8'h00, 8'h00);
    // One low cycle is a glitch, not a request
    ext[24] <= 1'b0;
    @(posedge ref_clk);
    ext[24] <= 1'b1;
    repeat (6) @(posedge ref_clk);
    `CHK(irqReq[24], 1'b0)
    ext[24] <= 1'b0;
    irqw(24, 1'b1);
    ext[24] <= 1'b1;
    irqw(24, 1'b0);
    cfg(3, 8'hFF, 8'hFF, 8'hFF, 8'hFF);
    irqw(25, 1'b0);
    ext[25] <= 1'b0;
    repeat (6) @(posedge ref_clk);
    `CHK(irqReq[25], 1'b0)
    ext[25] <= 1'b1;
    irqw(25, 1'b1);
    wr(gpmi_pkg::IDX_DATA[3], 8'h00);
    `CHK(irqReq[25], 1'b1)
    wr(gpmi_pkg::IDX_DATA[3], 8'hFF);
    irqw(25, 1'b0);
    // Falling-edge mode 9 on port B, entered with data bits low
    cfg(1, 8'hFF, 8'hFF, 8'hFF, 8'h00);
    irqw(9, 1'b0);
    ext[9] <= 1'b0;
    irqw(9, 1'b1);
    wr(gpmi_pkg::IDX_DATA[1], 8'hFF);
    irqw(9, 1'b0);
    rdc(gpmi_pkg::IDX_DATA[1], 8'h94);
    cfg(0, 8'hFF, 8'h00, 8'h00, 8'hFF);
    ext[3] <= 1'b1;
    irqw(3, 1'b1);
    wr(gpmi_pkg::IDX_DATA[0], 8'hFF);
    irqw(3, 1'b0);
    repeat (6) @(posedge ref_clk);
    `CHK(irqReq[3], 1'b0)
    ext[3] <= 1'b0;
    irqw(3, 1'b1);
    wr(gpmi_pkg::IDX_DATA[0], 8'h00);
    `CHK(irqReq[3], 1'b1)
    stop_test();
  end
endmodule : tb_gpio_port_mode_interrupt
